// *** hw/flash_store_responder.sv ***
// Storage command responder with AXI4-Lite control registers
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module flash_store_responder #(
    parameter int IDX_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] strm_data,
    input wire logic strm_valid,
    input wire logic strm_last,
    input wire logic rx_broadcast,
    output logic strm_ready,
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic rsp_last,
    input wire logic rsp_ready,
    output logic [7:0] rsp_dst_endpoint,
    output logic rsp_explicit
);
    typedef enum logic {ST_RX, ST_TX} state_t;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] geom_r;
    logic [15:0] ok_cnt_r;
    logic [15:0] bad_cnt_r;
    logic [7:0] aw_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    logic aw_have_r;
    logic w_have_r;
    logic do_wr;

    assign do_wr = ce && aw_have_r && w_have_r && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_r <= 8'h00;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= flash_store_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_r <= awaddr;
                aw_have_r <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wd_r <= wdata;
                ws_r <= wstrb;
                w_have_r <= 1'b1;
                wready <= 1'b0;
            end
            if (do_wr)
            begin
                bvalid <= 1'b1;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bresp <= (aw_r == flash_store_pkg::CTRL_OFS || aw_r == flash_store_pkg::GEOM_OFS)
                    ? flash_store_pkg::RESP_OKAY : flash_store_pkg::RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= flash_store_pkg::CTRL_RESET;
            geom_r <= {flash_store_pkg::GEOM_SIZE_RESET, flash_store_pkg::GEOM_BLOCKS_RESET};
        end
        else if (do_wr)
        begin
            if (aw_r == flash_store_pkg::CTRL_OFS)
                ctrl_r <= merge(ctrl_r, wd_r, ws_r) & 32'h0000_0007;
            if (aw_r == flash_store_pkg::GEOM_OFS)
                geom_r <= merge(geom_r, wd_r, ws_r);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= flash_store_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= flash_store_pkg::RESP_OKAY;
                case (araddr)
                    flash_store_pkg::CTRL_OFS: rdata <= ctrl_r;
                    flash_store_pkg::GEOM_OFS: rdata <= geom_r;
                    flash_store_pkg::STAT_OFS: rdata <= {bad_cnt_r, ok_cnt_r};
                    default:
                    begin
                        rdata <= 32'h0000_0000;
                        rresp <= flash_store_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    state_t state_r;
    logic [IDX_W-1:0] idx_r;
    logic [7:0] sum_r;
    logic [7:0] src_ep_r;
    logic [7:0] dst_ep_r;
    logic [15:0] cluster_r;
    logic [7:0] cmd_r;
    logic [15:0] blk_r;
    logic [15:0] off_r;
    logic [7:0] rsp_mem_r [0:7];
    logic [2:0] tx_idx_r;
    logic take;
    logic fin;
    logic sum_ok;
    logic addr_ok;
    logic long_ok;
    logic ld;
    logic is_geo;
    logic [IDX_W-1:0] pidx;

    assign take = ce && state_r == ST_RX && strm_valid && strm_ready;
    assign fin = take && strm_last;
    assign pidx = idx_r - IDX_W'(flash_store_pkg::HDR_BYTES);
    assign sum_ok = 8'(sum_r + strm_data) == flash_store_pkg::CSUM_GOOD;
    assign addr_ok = cluster_r == flash_store_pkg::STORE_CLUSTER
        && dst_ep_r == flash_store_pkg::DEVICE_ENDPOINT;
    assign long_ok = idx_r >= IDX_W'(flash_store_pkg::HDR_BYTES + flash_store_pkg::DATA_POS);
    // Whole frame seen and checked before any decode
    assign ld = fin && sum_ok && addr_ok && long_ok && !rx_broadcast
        && ctrl_r[flash_store_pkg::CTRL_EN_BIT];
    assign is_geo = cmd_r == flash_store_pkg::CMD_GEOMETRY_QUERY;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            idx_r <= '0;
            sum_r <= 8'h00;
            src_ep_r <= 8'h00;
            dst_ep_r <= 8'h00;
            cluster_r <= 16'h0000;
            cmd_r <= 8'h00;
            blk_r <= 16'h0000;
            off_r <= 16'h0000;
        end
        else if (take)
        begin
            idx_r <= strm_last ? '0 : idx_r + 1'b1;
            sum_r <= strm_last ? 8'h00 : 8'(sum_r + strm_data);
            if (idx_r == IDX_W'(flash_store_pkg::SRC_EP_POS))
                src_ep_r <= strm_data;
            if (idx_r == IDX_W'(flash_store_pkg::DST_EP_POS))
                dst_ep_r <= strm_data;
            if (idx_r == IDX_W'(flash_store_pkg::CLUSTER_POS))
                cluster_r[15:8] <= strm_data;
            if (idx_r == IDX_W'(flash_store_pkg::CLUSTER_POS + 1))
                cluster_r[7:0] <= strm_data;
            if (pidx == IDX_W'(flash_store_pkg::CMD_POS))
                cmd_r <= strm_data;
            // High byte first on every two-byte field
            if (pidx == IDX_W'(flash_store_pkg::BLK_POS))
                blk_r[15:8] <= strm_data;
            if (pidx == IDX_W'(flash_store_pkg::BLK_POS + 1))
                blk_r[7:0] <= strm_data;
            if (pidx == IDX_W'(flash_store_pkg::OFF_POS))
                off_r[15:8] <= strm_data;
            if (pidx == IDX_W'(flash_store_pkg::OFF_POS + 1))
                off_r[7:0] <= strm_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ok_cnt_r <= 16'h0000;
            bad_cnt_r <= 16'h0000;
        end
        else
        begin
            if (ld)
                ok_cnt_r <= ok_cnt_r + 1'b1;
            if (fin && !sum_ok)
                bad_cnt_r <= bad_cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Response build and send
    // ------------------------------------------------------------
    // Stream stalls while a reply drains, no buffering of a second frame
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_RX;
            strm_ready <= 1'b1;
            tx_idx_r <= 3'h0;
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
            rsp_data <= 8'h00;
            rsp_dst_endpoint <= 8'h00;
            rsp_explicit <= 1'b0;
            for (int i = 0; i < 8; i++)
                rsp_mem_r[i] <= 8'h00;
        end
        else if (ce)
        begin
            case (state_r)
                ST_RX:
                begin
                    if (ld)
                    begin
                        state_r <= ST_TX;
                        strm_ready <= 1'b0;
                        tx_idx_r <= 3'h0;
                        rsp_dst_endpoint <= src_ep_r;
                        rsp_explicit <= ctrl_r[flash_store_pkg::CTRL_FRAME_BIT]
                            && (src_ep_r == flash_store_pkg::DEVICE_ENDPOINT
                            || ctrl_r[flash_store_pkg::CTRL_EXPL_BIT]);
                        rsp_mem_r[0] <= cmd_r | flash_store_pkg::CMD_REPLY_BIT;
                        rsp_mem_r[1] <= is_geo ? flash_store_pkg::RESULT_OK
                            : flash_store_pkg::RESULT_UNSUPPORTED;
                        rsp_mem_r[2] <= is_geo ? geom_r[15:8] : blk_r[15:8];
                        rsp_mem_r[3] <= is_geo ? geom_r[7:0] : blk_r[7:0];
                        rsp_mem_r[4] <= is_geo ? geom_r[31:24] : off_r[15:8];
                        rsp_mem_r[5] <= is_geo ? geom_r[23:16] : off_r[7:0];
                        rsp_mem_r[6] <= 8'h00;
                        rsp_mem_r[7] <= 8'h00;
                    end
                end
                ST_TX:
                begin
                    if (!rsp_valid || rsp_ready)
                    begin
                        if (rsp_valid && rsp_last)
                        begin
                            rsp_valid <= 1'b0;
                            rsp_last <= 1'b0;
                            state_r <= ST_RX;
                            strm_ready <= 1'b1;
                        end
                        else
                        begin
                            rsp_valid <= 1'b1;
                            rsp_data <= rsp_mem_r[tx_idx_r];
                            rsp_last <= tx_idx_r == 3'h7;
                            tx_idx_r <= tx_idx_r + 1'b1;
                        end
                    end
                end
                default:
                    state_r <= ST_RX;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [15:0] geom_blk_h;
    logic [15:0] geom_sz_h;
    assign geom_blk_h = {rsp_mem_r[2], rsp_mem_r[3]};
    assign geom_sz_h = {rsp_mem_r[4], rsp_mem_r[5]};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    addr_filter_a: assert property (ld |-> cluster_r == 16'h0023 && dst_ep_r == 8'hE6)
        else $error("reply to wrong cluster or endpoint");
    no_bcast_a: assert property (fin && rx_broadcast |=> state_r == ST_RX)
        else $error("broadcast request answered");
    csum_gate_a: assert property (fin && !sum_ok |=> state_r == ST_RX && strm_ready)
        else $error("bad checksum frame answered");
    full_frame_a: assert property (state_r == ST_RX && $past(state_r) == ST_RX
        && !$past(fin) |-> !rsp_valid)
        else $error("reply before frame end");
    geo_code_a: assert property (ld && is_geo |=> rsp_mem_r[0] == 8'h80
        && rsp_mem_r[1] == 8'h00)
        else $error("geometry reply code or result wrong");
    err_code_a: assert property (ld && !is_geo |=> rsp_mem_r[1] != 8'h00)
        else $error("unsupported command reported success");
    geo_blocks_a: assert property (ld && is_geo |=> geom_blk_h == $past(geom_r[15:0])
        && geom_sz_h == $past(geom_r[31:16]))
        else $error("geometry fields wrong");
    geo_len_a: assert property (ld |=> rsp_mem_r[6] == 8'h00 && rsp_mem_r[7] == 8'h00)
        else $error("reply length not zero");
    reply_dst_a: assert property (ld |=> rsp_dst_endpoint == $past(src_ep_r))
        else $error("reply not aimed at source endpoint");
    reply_last_a: assert property (rsp_valid && rsp_last |-> tx_idx_r == 3'h0)
        else $error("reply not eight bytes");

    geo_done_c: cover property (ld && is_geo ##[1:40] rsp_valid && rsp_last && rsp_ready);
    bcast_drop_c: cover property (fin && rx_broadcast && sum_ok && addr_ok);
    bad_sum_c: cover property (fin && !sum_ok);
    reg_write_c: cover property (do_wr && aw_r == flash_store_pkg::GEOM_OFS);
endmodule

// *** hw/flash_store_pkg.sv ***
// Constants for the flash store command responder
package flash_store_pkg;
    // Addressing of storage requests
    localparam logic [15:0] STORE_CLUSTER = 16'h0023;
    localparam logic [7:0] DEVICE_ENDPOINT = 8'hE6;
    // Byte positions inside the frame stream, frame type at 0
    localparam int SRC_EP_POS = 11;
    localparam int DST_EP_POS = 12;
    localparam int CLUSTER_POS = 13;
    localparam int HDR_BYTES = 18;
    // Payload field positions
    localparam int CMD_POS = 0;
    localparam int OPT_POS = 1;
    localparam int BLK_POS = 2;
    localparam int OFF_POS = 4;
    localparam int LEN_POS = 6;
    localparam int DATA_POS = 8;
    // Commands and result codes
    localparam logic [7:0] CMD_GEOMETRY_QUERY = 8'h00;
    localparam logic [7:0] CMD_REPLY_BIT = 8'h80;
    localparam logic [7:0] RESULT_OK = 8'h00;
    localparam logic [7:0] RESULT_UNSUPPORTED = 8'h01;
    localparam logic [7:0] CSUM_GOOD = 8'hFF;
    // Register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] GEOM_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FRAME_BIT = 1;
    localparam int CTRL_EXPL_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [15:0] GEOM_BLOCKS_RESET = 16'h0077;
    localparam logic [15:0] GEOM_SIZE_RESET = 16'h0200;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** tb/req_host_model.sv ***
// Requester model: frame byte source and reply sink
`timescale 1ns/1ps
module req_host_model (
    input wire logic aclk,
    output logic [7:0] strm_data,
    output logic strm_valid,
    output logic strm_last,
    output logic rx_broadcast,
    input wire logic strm_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_last,
    output logic rsp_ready
);
    logic slow = 1'b0;
    logic [8:0] rx_q[$];
    initial
    begin
        strm_data = 8'h00;
        strm_valid = 1'b0;
        strm_last = 1'b0;
        rx_broadcast = 1'b0;
        rsp_ready = 1'b0;
    end
    // Slow mode drops rsp_ready on every other cycle, so each reply beat can stall
    always @(posedge aclk) rsp_ready <= slow ? ~rsp_ready : 1'b1;
    always @(posedge aclk)
    begin
        if (rsp_valid && rsp_ready)
            rx_q.push_back({rsp_last, rsp_data});
    end
    // Model has no sleep state, so no update ever overlaps sleep
    task automatic send(input logic [7:0] f[$], input logic bc, input logic bad);
        logic [7:0] sum;
        int n;
        sum = 8'h00;
        foreach (f[i]) sum += f[i];
        f.push_back((8'hFF - sum) ^ {7'h00, bad});
        @(posedge aclk);
        foreach (f[i])
        begin
            strm_data <= f[i];
            strm_valid <= 1'b1;
            strm_last <= (i == f.size() - 1);
            rx_broadcast <= bc;
            n = 0;
            do
            begin
                @(negedge aclk);
                n++;
            end
            while (strm_ready !== 1'b1 && n < 100);
            @(posedge aclk);
        end
        strm_valid <= 1'b0;
        strm_last <= 1'b0;
        // Released lines toggle so no stale byte can look valid
        strm_data <= ~strm_data;
    endtask
endmodule

// *** tb/tb_flash_store_command_responder.sv ***
// Testbench for the flash store command responder
`timescale 1ns/1ps
module tb_flash_store_command_responder;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, strm_ready, rsp_valid, rsp_last, rsp_ready;
    logic strm_valid, strm_last, rx_broadcast, rsp_explicit;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] strm_data, rsp_data, rsp_dst_endpoint;
    int failures = 0;
    int tests_run = 0;
    logic [7:0] fr[$];
    always #2.5 aclk = ~aclk;
    flash_store_responder DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .strm_data(strm_data), .strm_valid(strm_valid), .strm_last(strm_last),
        .rx_broadcast(rx_broadcast), .strm_ready(strm_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
        .rsp_dst_endpoint(rsp_dst_endpoint), .rsp_explicit(rsp_explicit));
    req_host_model M (.aclk(aclk), .strm_data(strm_data), .strm_valid(strm_valid),
        .strm_last(strm_last), .rx_broadcast(rx_broadcast), .strm_ready(strm_ready),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
        .rsp_ready(rsp_ready));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb, done;
        logic [1:0] r;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            done = tb;
        end
        chk(done && r === er, "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
        input int hold = 0);
        logic ta, t, done;
        logic [1:0] r;
        logic [31:0] d;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // Frozen clock enable must leave the read untaken
        if (hold > 0)
        begin
            ce <= 1'b0;
            repeat (hold) @(posedge aclk);
            @(negedge aclk);
            chk(arready === 1'b1 && rvalid === 1'b0, "bus moved while frozen");
            @(posedge aclk);
            ce <= 1'b1;
        end
        for (int n = 0; n < 100 && !done; n++)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (t) rready <= 1'b0;
            done = t;
        end
        chk(done && d === ed && r === er, "read data");
    endtask
    task automatic mk(input logic [7:0] cmd, input logic [15:0] blk, off, len,
        input logic [7:0] src, dst, input logic [15:0] clu);
        fr = {8'h91, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'hFF, 8'hFE,
            src, dst, clu[15:8], clu[7:0], 8'hC1, 8'h05, 8'h01, cmd, 8'h00,
            blk[15:8], blk[7:0], off[15:8], off[7:0], len[15:8], len[7:0]};
    endtask
    task automatic expect_reply(input logic [63:0] e, input logic [7:0] ep, input logic ex);
        for (int n = 0; n < 200 && M.rx_q.size() < 8; n++) @(posedge aclk);
        repeat (10) @(posedge aclk);
        @(negedge aclk);
        chk(M.rx_q.size() == 8, "reply length");
        for (int i = 0; i < M.rx_q.size() && i < 8; i++)
            chk(M.rx_q[i] === {i == 7, e[63 - 8 * i -: 8]}, "reply byte");
        chk(rsp_dst_endpoint === ep, "reply endpoint");
        chk(rsp_explicit === ex, "presentation flag");
        M.rx_q.delete();
    endtask
    task automatic expect_none();
        repeat (60) @(posedge aclk);
        chk(M.rx_q.size() == 0, "unexpected reply");
        M.rx_q.delete();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        @(negedge aclk);
        chk(awready && wready && arready && strm_ready && !bvalid && !rvalid && !rsp_valid
            && rdata === 32'h0000_0000 && rsp_explicit === 1'b0, "reset state");
        axi_rd(flash_store_pkg::CTRL_OFS, flash_store_pkg::CTRL_RESET, flash_store_pkg::RESP_OKAY);
        axi_rd(flash_store_pkg::GEOM_OFS, {flash_store_pkg::GEOM_SIZE_RESET,
            flash_store_pkg::GEOM_BLOCKS_RESET}, flash_store_pkg::RESP_OKAY);
        axi_rd(8'h0C, 32'h0000_0000, flash_store_pkg::RESP_SLVERR);
        axi_wr(flash_store_pkg::STAT_OFS, 32'hFFFF_FFFF, flash_store_pkg::RESP_SLVERR);
        axi_wr(8'h10, 32'hFFFF_FFFF, flash_store_pkg::RESP_SLVERR);
        axi_rd(flash_store_pkg::STAT_OFS, 32'h0000_0000, flash_store_pkg::RESP_OKAY);
    endtask
    task automatic t_geom();
        mk(8'h00, 16'h0000, 16'h0000, 16'h0000, 8'hE6, 8'hE6, 16'h0023);
        M.send(fr, 1'b0, 1'b0);
        expect_reply({8'h80, 8'h00, flash_store_pkg::GEOM_BLOCKS_RESET,
            flash_store_pkg::GEOM_SIZE_RESET, 16'h0000}, 8'hE6, 1'b1);
        axi_rd(flash_store_pkg::STAT_OFS, 32'h0000_0001, flash_store_pkg::RESP_OKAY);
    endtask
    task automatic t_drop();
        M.send(fr, 1'b1, 1'b0);
        expect_none();
        M.send(fr, 1'b0, 1'b1);
        expect_none();
        mk(8'h00, 16'h0000, 16'h0000, 16'h0000, 8'hE6, 8'hE6, 16'h0024);
        M.send(fr, 1'b0, 1'b0);
        expect_none();
        mk(8'h00, 16'h0000, 16'h0000, 16'h0000, 8'hE6, 8'hE8, 16'h0023);
        M.send(fr, 1'b0, 1'b0);
        expect_none();
        axi_rd(flash_store_pkg::STAT_OFS, 32'h0001_0001, flash_store_pkg::RESP_OKAY);
    endtask
    task automatic t_other();
        axi_wr(flash_store_pkg::GEOM_OFS, 32'h0100_0010, flash_store_pkg::RESP_OKAY);
        // One byte lane only, the rest must survive
        wstrb <= 4'h4;
        axi_wr(flash_store_pkg::GEOM_OFS, 32'hFFAB_FFFF, flash_store_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(flash_store_pkg::GEOM_OFS, 32'h01AB_0010, flash_store_pkg::RESP_OKAY);
        axi_wr(flash_store_pkg::GEOM_OFS, 32'h0100_0010, flash_store_pkg::RESP_OKAY);
        mk(8'h01, 16'h002A, 16'h0005, 16'h0000, 8'h10, 8'hE6, 16'h0023);
        M.send(fr, 1'b0, 1'b0);
        expect_reply(64'h8101_002A_0005_0000, 8'h10, 1'b0);
    endtask
    task automatic t_modes();
        // Slow sink proves the reply holds each byte across stalls
        axi_wr(flash_store_pkg::CTRL_OFS, 32'hFFFF_FFFF, flash_store_pkg::RESP_OKAY);
        axi_rd(flash_store_pkg::CTRL_OFS, 32'h0000_0007, flash_store_pkg::RESP_OKAY, 12);
        M.slow = 1'b1;
        mk(8'h00, 16'h0000, 16'h0000, 16'h0000, 8'h20, 8'hE6, 16'h0023);
        M.send(fr, 1'b0, 1'b0);
        expect_reply(64'h8000_0010_0100_0000, 8'h20, 1'b1);
        M.slow = 1'b0;
        axi_wr(flash_store_pkg::CTRL_OFS, 32'h0000_0005, flash_store_pkg::RESP_OKAY);
        mk(8'h00, 16'h0000, 16'h0000, 16'h0000, 8'hE6, 8'hE6, 16'h0023);
        M.send(fr, 1'b0, 1'b0);
        expect_reply(64'h8000_0010_0100_0000, 8'hE6, 1'b0);
        axi_wr(flash_store_pkg::CTRL_OFS, 32'h0000_0002, flash_store_pkg::RESP_OKAY);
        M.send(fr, 1'b0, 1'b0);
        expect_none();
    endtask
    task automatic print_verdict();
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_geom();
        t_drop();
        t_other();
        t_modes();
        print_verdict();
    end
    // Whole run needs well under 20000 cycles
    initial
    begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule
